// ### include/sbl_pkg.sv
// Constants, state encoding and state record of the serial EEPROM boot loader
package sbl_pkg;
    // Strap value selecting SDRAM boot from serial EEPROM
    localparam logic [1:0]  SBL_STRAP_SERIAL  = 2'h3;
    // Serial port B field values forced during boot
    localparam logic        SBL_BOOT_CE       = 1'h1;
    localparam logic [1:0]  SBL_BOOT_WLEN     = 2'h3;
    localparam logic        SBL_BOOT_SEL_POL  = 1'h0;
    localparam logic [1:0]  SBL_BOOT_MODE     = 2'h2;
    localparam logic        SBL_BOOT_ORDER    = 1'h1;
    localparam logic        SBL_BOOT_FLAG     = 1'h1;
    localparam logic [11:0] SBL_BOOT_DIV      = 12'h00f;
    // Serial port B default field values, loaded when done
    localparam logic        SBL_DEF_CE        = 1'h0;
    localparam logic [1:0]  SBL_DEF_WLEN      = 2'h0;
    localparam logic        SBL_DEF_SEL_POL   = 1'h0;
    localparam logic [1:0]  SBL_DEF_MODE      = 2'h0;
    localparam logic        SBL_DEF_ORDER     = 1'h0;
    localparam logic        SBL_DEF_FLAG      = 1'h0;
    localparam logic [11:0] SBL_DEF_DIV       = 12'h000;
    // Word positions in the EEPROM stream
    localparam logic [31:0] SBL_IDX_COUNT     = 32'h1;
    localparam logic [31:0] SBL_IDX_IMAGE     = 32'h21;
    localparam logic [1:0]  SBL_LAST_BYTE     = 2'h3;
    localparam logic [31:0] SBL_WORD_BYTES    = 32'h4;
    // Count is unknown until word 1 arrives, so start at the maximum
    localparam logic [31:0] SBL_NUM_WORDS_RST = 32'hffffffff;

    typedef enum logic [2:0] {
        SBL_IDLE, SBL_XFER, SBL_WORD, SBL_CFG_WR, SBL_MEM_WR, SBL_NEXT,
        SBL_RESTORE, SBL_DONE
    } sbl_state_t;

    typedef struct packed {
        sbl_state_t  st;
        logic        serial;
        logic        hold;
        logic        done;
        logic        active;
        logic [7:0]  tx_byte;
        logic [1:0]  byte_cnt;
        logic [31:0] word;
        logic [31:0] num_words;
        logic [31:0] word_idx;
        logic [31:0] mem_addr;
        logic        ce;
        logic [1:0]  wlen;
        logic        sel_pol;
        logic [1:0]  mode;
        logic        order;
        logic        rate_en;
        logic        sync_tim;
        logic        ref_sel;
        logic        tx_inv;
        logic [11:0] div;
    } sbl_regs_t;

    // Port B leaves reset already in SPI master mode
    localparam sbl_regs_t SBL_REGS_RST = '{
        st: SBL_IDLE, serial: 1'h0, hold: 1'h1, done: 1'h0, active: 1'h0,
        tx_byte: 8'h00, byte_cnt: 2'h0, word: 32'h0,
        num_words: SBL_NUM_WORDS_RST, word_idx: 32'h0, mem_addr: 32'h0,
        ce: SBL_BOOT_CE, wlen: SBL_BOOT_WLEN, sel_pol: SBL_BOOT_SEL_POL,
        mode: SBL_BOOT_MODE, order: SBL_BOOT_ORDER, rate_en: SBL_BOOT_FLAG,
        sync_tim: SBL_BOOT_FLAG, ref_sel: SBL_BOOT_FLAG, tx_inv: SBL_BOOT_FLAG,
        div: SBL_BOOT_DIV};
endpackage

// ### rtl/sbl_loader.sv
// Serial EEPROM boot loader driving serial port B and system memory
//
// Operation
// - Loader runs only when the boot strap reads 11.
// - Straps 00, 01, 10 mean parallel boot; loader stays idle.
// - Loader copies EEPROM contents to memory through serial port B.
// - Only serial port B is used; the EEPROM must sit on it.
// - Port B is in SPI master mode right out of reset.
// - After the copy every changed port B field returns to default.
// - Boot sets channel enable to 1 and word length to 3.
// - Boot sets select polarity 0 and port mode 2, SPI master.
// - Boot sets shift order to 1, most significant bit first.
// - Boot sets rate enable, sync timing, clock select, tx invert to 1.
// - Boot loads rate divisor with 00f for a 1.5 MHz clock.
// - Copy takes about one serial clock per EEPROM bit.
// - Memory controller is configured before any memory write.
// - EEPROM starts with a header; first word slot is discarded.
// - Header word count gives total words; exactly that many fetched.
`timescale 1ns/10ps
`default_nettype none
module sbl_loader #(
    parameter logic [7:0]  READ_CMD = 8'h03,      // EEPROM read opcode
    parameter logic [31:0] MEM_BASE = 32'h0       // Image load address
) (
    input  wire logic         core_clk,           // 10 MHz clock
    input  wire logic         rstn,               // Async reset, active low
    input  wire logic [1:0]   boot_cfg,           // Boot strap
    output logic              spi_xfer_req,       // Byte exchange request
    output logic [7:0]        spi_tx_byte,        // Byte to send
    input  wire logic         spi_xfer_ack,       // Exchange done pulse
    input  wire logic [7:0]   spi_rx_byte,        // Byte received
    output logic              eeprom_read_active, // Read frame open
    output logic              cfg_wr_valid,       // Controller config write
    input  wire logic         cfg_wr_ready,       // Config write taken
    output logic [5:0]        cfg_wr_index,       // Header word position
    output logic [31:0]       cfg_wr_data,        // Header word
    output logic              mem_wr_valid,       // Memory write
    input  wire logic         mem_wr_ready,       // Memory write taken
    output logic [31:0]       mem_wr_addr,        // Memory byte address
    output logic [31:0]       mem_wr_data,        // Image word
    output logic              chan_enable,        // Port B channel enable
    output logic [1:0]        word_length_select, // Port B word length
    output logic              select_polarity,    // Port B select polarity
    output logic [1:0]        port_mode,          // Port B mode
    output logic              shift_order_select, // Port B bit order
    output logic              rate_generator_enable, // Rate generator on
    output logic              timing_select,      // Port B sync timing
    output logic              reference_clock_select, // Rate reference
    output logic              transmit_clock_invert,  // Tx clock invert
    output logic [11:0]       rate_divisor,       // Rate divisor
    output logic              cpu_hold,           // Hold processor fetch
    output logic              boot_done,          // Loader finished
    output logic              serial_boot         // Serial boot selected
);
    import sbl_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // State
    sbl_regs_t st_reg;
    sbl_regs_t st_next;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= SBL_REGS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        st_next = st_reg;
        unique case (st_reg.st)
            SBL_IDLE: begin
                st_next.serial = (boot_cfg == SBL_STRAP_SERIAL);
                st_next.mem_addr = MEM_BASE;
                if (boot_cfg == SBL_STRAP_SERIAL) begin
                    st_next.st = SBL_XFER;
                    st_next.tx_byte = READ_CMD;
                    st_next.active = 1'h1;
                end else begin
                    st_next.st = SBL_RESTORE;
                end
            end
            SBL_XFER: begin
                if (spi_xfer_ack) begin
                    // first byte lands in low lane
                    st_next.word[{st_reg.byte_cnt, 3'h0} +: 8] = spi_rx_byte;
                    // Address bytes and later slots are sent as zero
                    st_next.tx_byte = 8'h00;
                    st_next.byte_cnt = st_reg.byte_cnt + 2'h1;
                    if (st_reg.byte_cnt == SBL_LAST_BYTE) begin
                        st_next.st = SBL_WORD;
                    end
                end
            end
            SBL_WORD: begin
                if (st_reg.word_idx == SBL_IDX_COUNT) begin
                    st_next.num_words = st_reg.word;
                end
                if (st_reg.word_idx >= SBL_IDX_IMAGE) begin
                    st_next.st = SBL_MEM_WR;
                end else if (st_reg.word_idx > SBL_IDX_COUNT) begin
                    st_next.st = SBL_CFG_WR;
                end else begin
                    st_next.st = SBL_NEXT;
                end
            end
            SBL_CFG_WR: begin
                if (cfg_wr_ready) begin
                    st_next.st = SBL_NEXT;
                end
            end
            SBL_MEM_WR: begin
                if (mem_wr_ready) begin
                    st_next.mem_addr = st_reg.mem_addr + SBL_WORD_BYTES;
                    st_next.st = SBL_NEXT;
                end
            end
            SBL_NEXT: begin
                st_next.word_idx = st_reg.word_idx + 32'h1;
                // stop after exactly the counted words
                if (st_reg.word_idx + 32'h1 >= st_reg.num_words) begin
                    st_next.st = SBL_RESTORE;
                    st_next.active = 1'h0;
                end else begin
                    st_next.st = SBL_XFER;
                end
            end
            SBL_RESTORE: begin
                // port B back to default values
                st_next.ce = SBL_DEF_CE;
                st_next.wlen = SBL_DEF_WLEN;
                st_next.sel_pol = SBL_DEF_SEL_POL;
                st_next.mode = SBL_DEF_MODE;
                st_next.order = SBL_DEF_ORDER;
                st_next.rate_en = SBL_DEF_FLAG;
                st_next.sync_tim = SBL_DEF_FLAG;
                st_next.ref_sel = SBL_DEF_FLAG;
                st_next.tx_inv = SBL_DEF_FLAG;
                st_next.div = SBL_DEF_DIV;
                st_next.st = SBL_DONE;
            end
            SBL_DONE: begin
                st_next.hold = 1'h0;
                st_next.done = 1'h1;
            end
        endcase
    end

    // ==========================================================
    // Outputs
    // next byte requested right after each ack, except after the last byte of a word
    assign spi_xfer_req           = (st_reg.st == SBL_XFER);
    assign spi_tx_byte            = st_reg.tx_byte;
    assign eeprom_read_active     = st_reg.active;
    assign cfg_wr_valid           = (st_reg.st == SBL_CFG_WR);
    assign cfg_wr_index           = st_reg.word_idx[5:0];
    assign cfg_wr_data            = st_reg.word;
    assign mem_wr_valid           = (st_reg.st == SBL_MEM_WR);
    assign mem_wr_addr            = st_reg.mem_addr;
    assign mem_wr_data            = st_reg.word;
    assign chan_enable            = st_reg.ce;
    assign word_length_select     = st_reg.wlen;
    assign select_polarity        = st_reg.sel_pol;
    assign port_mode              = st_reg.mode;
    assign shift_order_select     = st_reg.order;
    assign rate_generator_enable  = st_reg.rate_en;
    assign timing_select          = st_reg.sync_tim;
    assign reference_clock_select = st_reg.ref_sel;
    assign transmit_clock_invert  = st_reg.tx_inv;
    assign rate_divisor           = st_reg.div;
    assign cpu_hold               = st_reg.hold;
    assign boot_done              = st_reg.done;
    assign serial_boot            = st_reg.serial;

    // ==========================================================
    // Checks
    sequence s_release;
        (!spi_xfer_req)[*2] ##1 boot_done;
    endsequence
    sequence s_drop_word;
        (!cfg_wr_valid && !mem_wr_valid) ##1 spi_xfer_req;
    endsequence
    sequence s_req_stands;
        spi_xfer_req && $stable(spi_tx_byte);
    endsequence

    a_strap_enable: assert property (st_reg.st == SBL_IDLE && boot_cfg == SBL_STRAP_SERIAL
        |=> spi_xfer_req && spi_tx_byte == READ_CMD)
        else $error("serial boot not started");
    a_strap_bypass: assert property (st_reg.st == SBL_IDLE && boot_cfg != SBL_STRAP_SERIAL
        |=> s_release)
        else $error("parallel boot touched eeprom");
    a_mem_step: assert property (mem_wr_valid && mem_wr_ready
        |=> mem_wr_addr == $past(mem_wr_addr) + SBL_WORD_BYTES)
        else $error("memory address not advanced");
    a_port_only: assert property (spi_xfer_req |-> eeprom_read_active
        && serial_boot)
        else $error("exchange outside serial boot");
    a_spi_reset: assert property (st_reg.st == SBL_IDLE |-> port_mode == SBL_BOOT_MODE
        && chan_enable == SBL_BOOT_CE)
        else $error("port b not spi at reset");
    a_port_restore: assert property (boot_done |-> chan_enable == SBL_DEF_CE
        && port_mode == SBL_DEF_MODE && rate_divisor == SBL_DEF_DIV
        && word_length_select == SBL_DEF_WLEN)
        else $error("port b not restored");
    a_enable_wlen: assert property (spi_xfer_req |-> chan_enable == SBL_BOOT_CE
        && word_length_select == SBL_BOOT_WLEN)
        else $error("wrong enable or length");
    a_mode_pol: assert property (spi_xfer_req |-> select_polarity == SBL_BOOT_SEL_POL
        && port_mode == SBL_BOOT_MODE)
        else $error("wrong polarity or mode");
    a_bit_order: assert property (spi_xfer_req
        |-> shift_order_select == SBL_BOOT_ORDER)
        else $error("wrong bit order");
    a_rate_flags: assert property (spi_xfer_req |-> rate_generator_enable
        && timing_select && reference_clock_select && transmit_clock_invert)
        else $error("rate flags not set");
    a_rate_div: assert property (spi_xfer_req
        |-> rate_divisor == SBL_BOOT_DIV)
        else $error("wrong rate divisor");
    a_byte_stream: assert property (spi_xfer_ack && spi_xfer_req
        && st_reg.byte_cnt != SBL_LAST_BYTE |=> spi_xfer_req)
        else $error("gap inside word");
    a_cfg_first: assert property (mem_wr_valid
        |-> st_reg.word_idx >= SBL_IDX_IMAGE)
        else $error("memory write before config");
    a_pad_drop: assert property (st_reg.st == SBL_WORD && st_reg.word_idx == 32'h0
        |=> s_drop_word)
        else $error("command word not dropped");
    a_count_stop: assert property (st_reg.st == SBL_NEXT
        && st_reg.word_idx + 32'h1 >= st_reg.num_words
        |=> !eeprom_read_active ##1 !spi_xfer_req)
        else $error("fetch did not stop");
    a_hold_release: assert property ($fell(cpu_hold) |-> boot_done
        && chan_enable == SBL_DEF_CE && $past(st_reg.st) == SBL_DONE)
        else $error("processor released early");
    a_req_stands: assert property (spi_xfer_req && !spi_xfer_ack
        |=> s_req_stands)
        else $error("exchange request dropped");
    a_cfg_stands: assert property (cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid
        && $stable(cfg_wr_index) && $stable(cfg_wr_data))
        else $error("config write not held");
    a_mem_stands: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
        && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("memory write not held");
    a_first_cmd: assert property (spi_xfer_req && st_reg.word_idx == 32'h0
        && st_reg.byte_cnt == 2'h0 |-> spi_tx_byte == READ_CMD)
        else $error("read command not sent first");
    a_tx_zero: assert property (spi_xfer_req && st_reg.word_idx != 32'h0
        |-> spi_tx_byte == 8'h00)
        else $error("nonzero filler byte");
    a_cfg_window: assert property (cfg_wr_valid |-> st_reg.word_idx > SBL_IDX_COUNT
        && st_reg.word_idx < SBL_IDX_IMAGE)
        else $error("config write outside header");
    a_word_end: assert property (spi_xfer_req && spi_xfer_ack
        && st_reg.byte_cnt == SBL_LAST_BYTE |=> !spi_xfer_req)
        else $error("fifth byte in word");
    a_count_load: assert property (st_reg.st == SBL_WORD && st_reg.word_idx == SBL_IDX_COUNT
        |=> st_reg.num_words == $past(st_reg.word))
        else $error("word count not loaded");
    a_strap_latch: assert property (st_reg.st == SBL_IDLE
        |=> serial_boot == ($past(boot_cfg) == SBL_STRAP_SERIAL))
        else $error("strap not latched");
    a_bypass_quiet: assert property (!serial_boot |-> !spi_xfer_req && !cfg_wr_valid
        && !mem_wr_valid)
        else $error("activity without serial boot");
    a_addr_base: assert property (st_reg.st == SBL_IDLE
        |=> mem_wr_addr == MEM_BASE)
        else $error("load address not at base");
    a_restore_step: assert property (st_reg.st == SBL_RESTORE |=> cpu_hold
        && port_mode == SBL_DEF_MODE && rate_divisor == SBL_DEF_DIV)
        else $error("restore step wrong");
    a_flags_clear: assert property (boot_done |-> !rate_generator_enable && !timing_select
        && !reference_clock_select && !transmit_clock_invert)
        else $error("rate flags not cleared");
    a_order_clear: assert property (boot_done |-> shift_order_select == SBL_DEF_ORDER
        && select_polarity == SBL_DEF_SEL_POL)
        else $error("order or polarity not cleared");
    a_hold_busy: assert property (eeprom_read_active |-> cpu_hold
        && !boot_done)
        else $error("processor free during copy");
    a_done_stays: assert property (boot_done |=> boot_done
        && !cpu_hold)
        else $error("release not kept");
endmodule
`default_nettype wire

// ### dv/sbl_eeprom_model.sv
// Behavioural serial EEPROM answering the loader's byte exchanges
`timescale 1ns/10ps
`default_nettype none
module sbl_eeprom_model (
    input  wire logic        core_clk,     // System clock
    input  wire logic        rstn,         // Async reset, active low
    input  wire logic        spi_xfer_req, // Exchange request
    output logic             spi_xfer_ack, // Exchange done pulse
    output logic [7:0]       spi_rx_byte,  // Byte shifted out
    input  wire logic [31:0] num_words,    // Word count stored in header
    input  wire logic [3:0]  ack_delay     // Wait cycles per byte
);
    logic [7:0]  byte_reg;
    logic [31:0] bidx_reg;
    logic [3:0]  wait_reg;
    logic [31:0] cur_word;

    // ==========================================================
    // Image content
    function automatic logic [31:0] img(input logic [31:0] w, input logic [31:0] nw);
        if (w == 32'h0) return 32'hffffffff;
        if (w == 32'h1) return nw;
        return {w[7:0] ^ 8'h3c, w[7:0], 8'h96, w[7:0] + 8'h01};
    endfunction

    assign cur_word = img(bidx_reg >> 2, num_words);
    // Released line shows the inverse, so a stale byte is never taken as good
    assign spi_rx_byte = spi_xfer_ack ? byte_reg : ~byte_reg;

    // ==========================================================
    // Byte exchange
    // Little endian lanes in stored order
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            spi_xfer_ack <= 1'h0;
            byte_reg     <= 8'h00;
            bidx_reg     <= 32'h0;
            wait_reg     <= 4'h0;
        end else begin
            spi_xfer_ack <= 1'h0;
            if (spi_xfer_req && !spi_xfer_ack) begin
                if (wait_reg >= ack_delay) begin
                    spi_xfer_ack <= 1'h1;
                    byte_reg     <= cur_word[{bidx_reg[1:0], 3'h0} +: 8];
                    bidx_reg     <= bidx_reg + 32'h1;
                    wait_reg     <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/sbl_loader_tb_top.sv
// Self-checking bench of the serial EEPROM boot loader
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
    num_checks++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); \
    end \
end
module sbl_loader_tb_top;
    localparam logic [22:0] BOOT_FIELDS = {1'h1, 2'h3, 1'h0, 2'h2, 1'h1, 1'h1, 1'h1, 1'h1,
                                           1'h1, 12'h00f};
    logic        core_clk     = 1'h0;
    logic        rstn         = 1'h0;
    logic [1:0]  boot_cfg     = 2'h0;
    logic        cfg_wr_ready = 1'h0;
    logic        mem_wr_ready = 1'h0;
    logic [31:0] nwords       = 32'h0;
    logic [3:0]  ack_delay    = 4'h0;
    logic [3:0]  cyc          = 4'h0;
    logic        spi_xfer_req, spi_xfer_ack, eeprom_read_active, cfg_wr_valid, mem_wr_valid;
    logic [7:0]  spi_tx_byte, spi_rx_byte;
    logic [5:0]  cfg_wr_index;
    logic [31:0] cfg_wr_data, mem_wr_addr, mem_wr_data;
    logic        chan_enable, select_polarity, shift_order_select, rate_generator_enable;
    logic        timing_select, reference_clock_select, transmit_clock_invert;
    logic [1:0]  word_length_select, port_mode;
    logic [11:0] rate_divisor;
    logic        cpu_hold, boot_done, serial_boot;
    logic [22:0] fields;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          n_xfer, n_cfg, n_mem;

    assign fields = {chan_enable, word_length_select, select_polarity, port_mode,
                     shift_order_select, rate_generator_enable, timing_select,
                     reference_clock_select, transmit_clock_invert, rate_divisor};

    always #50 core_clk = ~core_clk;

    sbl_loader #(.READ_CMD(8'h03), .MEM_BASE(32'h0)) DUT (
        .core_clk(core_clk), .rstn(rstn), .boot_cfg(boot_cfg),
        .spi_xfer_req(spi_xfer_req), .spi_tx_byte(spi_tx_byte),
        .spi_xfer_ack(spi_xfer_ack), .spi_rx_byte(spi_rx_byte),
        .eeprom_read_active(eeprom_read_active), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_ready(cfg_wr_ready), .cfg_wr_index(cfg_wr_index), .cfg_wr_data(cfg_wr_data),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .chan_enable(chan_enable),
        .word_length_select(word_length_select), .select_polarity(select_polarity),
        .port_mode(port_mode), .shift_order_select(shift_order_select),
        .rate_generator_enable(rate_generator_enable), .timing_select(timing_select),
        .reference_clock_select(reference_clock_select),
        .transmit_clock_invert(transmit_clock_invert), .rate_divisor(rate_divisor),
        .cpu_hold(cpu_hold), .boot_done(boot_done), .serial_boot(serial_boot));

    sbl_eeprom_model u_ee (
        .core_clk(core_clk), .rstn(rstn), .spi_xfer_req(spi_xfer_req),
        .spi_xfer_ack(spi_xfer_ack), .spi_rx_byte(spi_rx_byte),
        .num_words(nwords), .ack_delay(ack_delay));

    // ==========================================================
    // Stalling memory side and transfer monitor
    always @(posedge core_clk) begin
        cyc          <= cyc + 4'h1;
        cfg_wr_ready <= cyc[0];
        mem_wr_ready <= cyc[1];
        if (rstn) begin
            `CHK(cpu_hold, ~boot_done)
            if (eeprom_read_active) begin
                `CHK(fields, BOOT_FIELDS)
            end
            if (spi_xfer_req && spi_xfer_ack) begin
                `CHK(spi_tx_byte, (n_xfer == 0) ? 8'h03 : 8'h00)
                `CHK(eeprom_read_active, 1'h1)
                n_xfer++;
            end
            if (cfg_wr_valid && cfg_wr_ready) begin
                `CHK(cfg_wr_index, 6'(n_cfg + 2))
                `CHK(cfg_wr_data, u_ee.img(n_cfg + 2, nwords))
                n_cfg++;
            end
            if (mem_wr_valid && mem_wr_ready) begin
                `CHK(n_cfg, 31)
                `CHK(mem_wr_addr, 32'(4 * n_mem))
                `CHK(mem_wr_data, u_ee.img(33 + n_mem, nwords))
                n_mem++;
            end
        end
    end

    // ==========================================================
    // One boot from reset to release
    task automatic run_boot(input logic [1:0] strap, input logic [31:0] nw,
                            input logic [3:0] dly);
        int i;
        int exp_xfer;
        int exp_cfg;
        int exp_mem;
        @(posedge core_clk);
        rstn      <= 1'h0;
        boot_cfg  <= strap;
        nwords    <= nw;
        ack_delay <= dly;
        repeat (16) @(posedge core_clk);
        `CHK(fields, BOOT_FIELDS)
        `CHK(cpu_hold, 1'h1)
        n_xfer = 0;
        n_cfg  = 0;
        n_mem  = 0;
        rstn  <= 1'h1;
        for (i = 0; i < 5000 && boot_done !== 1'h1; i++) @(negedge core_clk);
        exp_xfer = (strap == 2'h3) ? 4 * int'(nw) : 0;
        exp_cfg  = (strap == 2'h3) ? ((nw > 33) ? 31 : int'(nw) - 2) : 0;
        exp_mem  = (strap == 2'h3 && nw > 33) ? int'(nw) - 33 : 0;
        `CHK(boot_done, 1'h1)
        `CHK(serial_boot, (strap == 2'h3))
        `CHK(n_xfer, exp_xfer)
        `CHK(n_cfg, exp_cfg)
        `CHK(n_mem, exp_mem)
        `CHK(fields, 23'h0)
        `CHK(cpu_hold, 1'h0)
        `CHK(eeprom_read_active, 1'h0)
        $display("Test strap %0h words %0d ended", strap, nw);
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        for (int s = 0; s < 3; s++) run_boot(2'(s), 32'h24, 4'h1);
        run_boot(2'h3, 32'h24, 4'h0);
        // Count ending inside the header: no memory write may follow
        run_boot(2'h3, 32'h14, 4'h3);
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
